// ==== bench/eep_master.sv ====
`timescale 1ns/1ps

module eep_master (
  // Clock
  input wire logic clock_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Quarter bit of 10 clocks keeps pin edges well apart
  localparam int Q = 10;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic q();
    repeat (Q) @(negedge clock_in);
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_low_out = ~b;
    q();
    scl_out = 1'b1;
    q();
    r = sda_in;
    q();
    scl_out = 1'b0;
  endtask
  // Also serves as repeated start
  task automatic start();
    q();
    sda_low_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_low_out = 1'b1;
    q();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_low_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_low_out = 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Master ack keeps a read going, nack ends it
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps

module tb;
  import eep_pkg::*;
  localparam logic [7:0] DEV = {TYPE_CODE, 3'b101, 1'b0};
  logic clock_in, srst_in, scl, m_low, wp, sda_oe, sda_o, busy, sda, ack;
  logic [2:0] strap;
  logic [7:0] d;
  logic [7:0] got [$];
  logic [7:0] v [$];
  int fails, cmp_count;
  // Pull-up wins unless someone pulls low
  assign sda = ~(m_low | (sda_oe & ~sda_o));
  eep_slave #(.PROG_CYCLES_P(1000)) eep_slave_inst (
    .clock_in(clock_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_strap_bit0_in(strap[0]),
    .addr_strap_bit1_in(strap[1]), .addr_strap_bit2_in(strap[2]),
    .wp_in(wp), .busy_out(busy));
  eep_master eep_master_inst (.clock_in(clock_in), .sda_in(sda),
    .scl_out(scl), .sda_low_out(m_low));
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmp8(input string n, input logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic dev(input logic rw, input logic e);
    eep_master_inst.start();
    eep_master_inst.send({DEV[7:1], rw}, ack);
    cmp1("address ack", e, ack);
  endtask
  task automatic set_addr(input logic [15:0] a);
    dev(1'b0, 1'b1);
    eep_master_inst.send(a[15:8], ack);
    cmp1("high address ack", 1'b1, ack);
    eep_master_inst.send(a[7:0], ack);
    cmp1("low address ack", 1'b1, ack);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    got = {};
    set_addr(a);
    dev(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      eep_master_inst.recv(i < n - 1, d);
      got.push_back(d);
    end
    eep_master_inst.stop();
  endtask
  task automatic wr(input logic [15:0] a, input logic pass);
    int k;
    set_addr(a);
    foreach (v[i]) begin
      eep_master_inst.send(v[i], ack);
      cmp1("data ack", pass, ack);
      if (!pass) break;
    end
    eep_master_inst.stop();
    cmp1("busy", pass, busy);
    if (pass) begin
      dev(1'b0, 1'b0);
      eep_master_inst.stop();
      k = 0;
      while (busy !== 1'b0 && k < 2000) begin
        @(negedge clock_in);
        k++;
      end
      cmp1("busy timer end", 1'b1, k < 2000);
      if (k < 2000) begin
        dev(1'b0, 1'b1);
        eep_master_inst.stop();
      end
    end
  endtask
  task automatic t_erased();
    rd(16'hc123, 2);
    cmp8("erased", 8'hff, got[0]);
    cmp8("erased next", 8'hff, got[1]);
  endtask
  // Wrong strap, then wrong type code
  task automatic t_select();
    eep_master_inst.start();
    eep_master_inst.send({TYPE_CODE, 3'b001, 1'b0}, ack);
    cmp1("strap mismatch", 1'b0, ack);
    eep_master_inst.start();
    eep_master_inst.send({4'hb, 3'b101, 1'b1}, ack);
    cmp1("type mismatch", 1'b0, ack);
    eep_master_inst.stop();
  endtask
  task automatic t_page_wrap();
    v = {8'h11, 8'h22, 8'h33};
    wr(16'h017e, 1'b1);
    rd(16'h017e, 3);
    cmp8("page byte 3e", 8'h11, got[0]);
    cmp8("page byte 3f", 8'h22, got[1]);
    cmp8("read past page", 8'hff, got[2]);
    rd(16'h0140, 1);
    cmp8("wrapped byte", 8'h33, got[0]);
    rd(16'h017e, 1);
    dev(1'b1, 1'b1);
    eep_master_inst.recv(1'b0, d);
    eep_master_inst.stop();
    cmp8("current address", 8'h22, d);
  endtask
  task automatic t_protect();
    wp = 1'b1;
    v = {8'h55};
    wr(16'h0200, 1'b0);
    wp = 1'b0;
    rd(16'h0200, 1);
    cmp8("protected", 8'hff, got[0]);
  endtask
  // 65 bytes: the last one lands on offset 0 again
  task automatic t_full_page();
    v = {};
    for (int i = 0; i < 65; i++) v.push_back(8'(i + 1));
    wr(16'h0080, 1'b1);
    rd(16'h0080, 64);
    cmp8("overwritten", 8'h41, got[0]);
    for (int i = 1; i < 64; i++) cmp8("page", 8'(i + 1), got[i]);
  endtask
  task automatic t_array_wrap();
    v = {8'h5a};
    wr(16'hffff, 1'b1);
    rd(16'h3fff, 2);
    cmp8("last location", 8'h5a, got[0]);
    cmp8("wrapped to zero", 8'hff, got[1]);
  endtask
  initial begin
    fails = 0;
    cmp_count = 0;
    srst_in = 1'b1;
    wp = 1'b0;
    strap = 3'b101;
    repeat (6) @(negedge clock_in);
    srst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    t_erased();
    t_select();
    t_page_wrap();
    t_protect();
    t_full_page();
    t_array_wrap();
    give_verdict();
  end
endmodule

// ==== logic/eep_pkg.sv ====
package eep_pkg;
  localparam logic [3:0] TYPE_CODE = 4'ha;
  localparam int ADDR_W = 14;
  localparam int OFFS_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int MEM_WORDS = 16384;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [5:0] SYNC_RST = 6'h03;
  localparam logic [5:0] OFFS_LAST = 6'h3f;
  localparam int FIFO_W = 14;
  localparam int FIFO_D = 8;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * CLK_FREQ_KHZ;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA
  } eep_bus_e;
  typedef enum logic [1:0] {B_IDLE, B_DRAIN, B_COPY, B_WAIT} eep_prog_e;
endpackage

// ==== logic/eep_slave.sv ====
// Function
// RULE1: SDA fall/rise with SCL high: START/STOP
// RULE2: Master holds SDA stable while SCL high
// RULE3: Ignore bus until START; STOP ends command
// RULE4: Address byte type code and straps must match
// RULE5: Address LSB one reads, zero writes
// RULE6: Acknowledge matching address on ninth clock
// RULE7: Acknowledge address and data bytes when writable
// RULE8: Read: shift byte, release, continue on ack
// RULE9: Two bytes load 14-bit address counter
// RULE10: Data goes to page buffer; STOP programs
// RULE11: While programming, SDA off, requests ignored
// RULE12: Up to 64 bytes per programming cycle
// RULE13: Page loading wraps within page offset
// RULE14: Commit only latest sequence, last values win
// RULE15: No address acknowledge while programming
// RULE16: Write protect high blocks all writes
// RULE17: Sample write protect before first data byte
// RULE18: Protected write: nack first byte, discard
// RULE19: Array starts erased to all ones
// RULE20: Read address returns current counter byte
// RULE21: Random read via address bytes, repeated START
// RULE22: Sequential read increments, wraps whole array
// RULE23: Sample on SCL rise, drive on fall, low only
// RULE24: Floating straps and protect read low
// RULE25: Busy interval from configurable timer
`timescale 1ns/1ps

module eep_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = wptr == rptr;
  wire do_push = in_valid_in && !full;
  wire do_pop = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rptr[AW-1:0]];

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (do_push) wptr <= wptr + 1'b1;
      if (do_pop) rptr <= rptr + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (do_push) mem[wptr[AW-1:0]] <= in_data_in;
  end
endmodule

module eep_slave #(
  parameter int PROG_CYCLES_P = eep_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Straps and protect
  input wire logic addr_strap_bit0_in,
  input wire logic addr_strap_bit1_in,
  input wire logic addr_strap_bit2_in,
  input wire logic wp_in,
  // Status
  output logic busy_out
);
  import eep_pkg::*;

  // Pins are asynchronous; scl_d/sda_d read only the second stage
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic scl_d;
  logic sda_d;
  eep_bus_e state;
  eep_prog_e bstate;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [ADDR_W-1:0] addr;
  logic sda_oe;
  logic rd_dir;
  logic wp_lat;
  logic mack;
  logic wr_pend;
  logic [OFFS_W-1:0] idx;
  logic [31:0] timer;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid;
  logic [7:0] mem [MEM_WORDS];
  logic next_ack;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;

  wire [5:0] raw = {wp_in, addr_strap_bit2_in, addr_strap_bit1_in,
                    addr_strap_bit0_in, sda_in, scl_in};
  wire scl = sync_b[0];
  wire sda = sync_b[1];
  wire [2:0] strap = sync_b[4:2]; // RULE24
  wire wp = sync_b[5]; // RULE24
  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start_cond = scl && scl_d && sda_d && !sda; // RULE1
  wire stop_cond = scl && scl_d && !sda_d && sda; // RULE1
  wire busy = bstate != B_IDLE;
  wire dev_match = shreg[7:4] == TYPE_CODE && shreg[3:1] == strap; // RULE4
  wire byte_done = scl_fall && cnt == BIT_LAST;
  wire ack_end = scl_fall && cnt == BIT_ACK;
  wire rx_state = state != ST_IDLE && state != ST_RDATA;
  wire [7:0] rd_byte = mem[addr];
  wire push = byte_done && state == ST_WDATA && !wp_lat
              && fifo_in_ready; // RULE16
  wire load_tx = ack_end && ((state == ST_DEVADDR && rd_dir)
                 || (state == ST_RDATA && mack)); // RULE8
  wire clr_valid = ack_end && state == ST_ADDR_LO;
  wire pop = fifo_out_valid && bstate != B_COPY;
  wire [OFFS_W-1:0] pop_offs = fifo_out_data[FIFO_W-1:8];
  wire timer_done = timer >= 32'(PROG_CYCLES_P - 1);

  assign sda_out = 1'b0; // RULE23
  assign sda_oe_out = sda_oe;
  assign busy_out = busy;

  always_comb begin
    case (state)
      ST_DEVADDR: next_ack = dev_match && !busy; // RULE6 RULE11 RULE15
      ST_ADDR_HI: next_ack = 1'b1; // RULE7
      ST_ADDR_LO: next_ack = 1'b1; // RULE7
      ST_WDATA: next_ack = push; // RULE18
      default: next_ack = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      scl_d <= sync_b[0];
      sda_d <= sync_b[1];
    end
  end

  // Bus sequencer: bits in on rise, out on fall
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      cnt <= '0;
      shreg <= '0;
      txreg <= '0;
      addr <= '0;
      sda_oe <= 1'b0;
      rd_dir <= 1'b0;
      wp_lat <= 1'b0;
      mack <= 1'b0;
      wr_pend <= 1'b0;
    end else if (start_cond) begin
      state <= ST_DEVADDR; // RULE3
      // START's own SCL fall wraps this to zero, so it is no data bit
      cnt <= '1;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE; // RULE3
      sda_oe <= 1'b0;
      wr_pend <= 1'b0;
    end else if (state != ST_IDLE) begin
      if (scl_rise && cnt < BIT_ACK && rx_state)
        shreg <= {shreg[6:0], sda}; // RULE23
      if (scl_rise && cnt == BIT_ACK && state == ST_RDATA)
        mack <= !sda; // RULE8
      if (scl_fall)
        cnt <= ack_end ? 4'h0 : cnt + 4'h1;
      if (byte_done && state != ST_RDATA) begin
        sda_oe <= next_ack; // RULE6
        if (!next_ack)
          state <= ST_IDLE; // RULE15
        case (state)
          ST_DEVADDR: rd_dir <= shreg[0]; // RULE5
          ST_ADDR_HI: addr[13:8] <= shreg[5:0]; // RULE9
          ST_ADDR_LO: addr[7:0] <= shreg; // RULE9
          ST_WDATA: begin
            if (push) begin
              addr[5:0] <= addr[5:0] + 6'h01; // RULE13
              wr_pend <= 1'b1; // RULE10
            end
          end
          default: ;
        endcase
      end else if (byte_done) begin
        sda_oe <= 1'b0; // RULE8
      end else if (scl_fall && state == ST_RDATA && cnt < BIT_LAST) begin
        txreg <= {txreg[6:0], 1'b0};
        sda_oe <= !txreg[6]; // RULE23
      end else if (load_tx) begin
        txreg <= rd_byte; // RULE20 RULE21
        addr <= addr + 14'h0001; // RULE22
        sda_oe <= !rd_byte[7];
        state <= ST_RDATA;
      end else if (ack_end) begin
        sda_oe <= 1'b0;
        case (state)
          ST_DEVADDR: state <= ST_ADDR_HI;
          ST_ADDR_HI: state <= ST_ADDR_LO;
          ST_ADDR_LO: begin
            state <= ST_WDATA;
            wp_lat <= wp; // RULE17
          end
          ST_RDATA: state <= ST_IDLE; // RULE8
          default: ;
        endcase
      end
    end
  end

  // Byte staging between bus and page buffer; stalls during copy
  eep_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({addr[5:0], shreg}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_out_data)
  );

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      valid <= '0;
    end else begin
      if (clr_valid)
        valid <= '0; // RULE14
      if (pop)
        valid[pop_offs] <= 1'b1; // RULE12
    end
  end

  always_ff @(posedge clock_in) begin
    if (pop) pbuf[pop_offs] <= fifo_out_data[7:0]; // RULE14
  end

  // Programming cycle: drain, copy marked bytes, then wait out timer
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      bstate <= B_IDLE;
      idx <= '0;
      timer <= '0;
    end else begin
      timer <= busy ? timer + 32'h1 : 32'h0; // RULE25
      case (bstate)
        B_IDLE: begin
          if (stop_cond && wr_pend && state == ST_WDATA)
            bstate <= B_DRAIN; // RULE10
        end
        B_DRAIN: begin
          idx <= '0;
          if (!fifo_out_valid) bstate <= B_COPY;
        end
        B_COPY: begin
          idx <= idx + 6'h01;
          if (idx == OFFS_LAST) bstate <= B_WAIT;
        end
        B_WAIT: begin
          if (timer_done) bstate <= B_IDLE; // RULE25
        end
        default: bstate <= B_IDLE;
      endcase
    end
  end

  // Erased contents at start; held across reset like a real array
  initial begin
    for (int i = 0; i < MEM_WORDS; i++) mem[i] = ERASED; // RULE19
  end

  always @(posedge clock_in) begin
    if (bstate == B_COPY && valid[idx])
      mem[{addr[13:6], idx}] <= pbuf[idx]; // RULE12 RULE14
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  property p_start;
    start_cond |=> state == ST_DEVADDR && !sda_oe;
  endproperty
  a_start: assert property (p_start) // RULE1
    else $error("start missed");

  property p_ack_addr;
    byte_done && state == ST_DEVADDR && dev_match && !busy
      |=> sda_oe && state == ST_DEVADDR;
  endproperty
  a_ack_addr: assert property (p_ack_addr) // RULE6
    else $error("no addr ack");

  property p_busy_nack;
    byte_done && state == ST_DEVADDR && busy |=> !sda_oe && state == ST_IDLE;
  endproperty
  a_busy_nack: assert property (p_busy_nack) // RULE15
    else $error("busy ack");

  property p_busy_quiet;
    busy && state == ST_IDLE |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) // RULE11
    else $error("busy drive");

  property p_busy_no_push;
    busy |-> !push;
  endproperty
  a_busy_no_push: assert property (p_busy_no_push) // RULE11
    else $error("busy push");

  property p_wp_reject;
    byte_done && state == ST_WDATA && wp_lat
      |=> !sda_oe && !wr_pend ##1 !wr_pend;
  endproperty
  a_wp_reject: assert property (p_wp_reject) // RULE18
    else $error("wp ignored");

  property p_wp_sample;
    ack_end && state == ST_ADDR_LO |=> wp_lat == $past(wp);
  endproperty
  a_wp_sample: assert property (p_wp_sample) // RULE17
    else $error("wp sample");

  property p_page_wrap;
    push |=> addr[13:6] == $past(addr[13:6])
      && addr[5:0] == $past(addr[5:0]) + 6'h01;
  endproperty
  a_page_wrap: assert property (p_page_wrap) // RULE13
    else $error("page incr");

  property p_read_incr;
    load_tx |=> addr == $past(addr) + 14'h0001 && txreg == $past(rd_byte);
  endproperty
  a_read_incr: assert property (p_read_incr) // RULE22
    else $error("read incr");

  property p_prog_end;
    bstate == B_WAIT && timer_done |=> bstate == B_IDLE ##1 !busy_out;
  endproperty
  a_prog_end: assert property (p_prog_end) // RULE25
    else $error("busy stuck");

  property p_drive_on_fall;
    $rose(sda_oe) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) // RULE23
    else $error("oe edge");

  c_read: cover property (load_tx ##[1:1000] stop_cond);
  c_write: cover property (push ##[1:1000] $rose(busy));
  c_wp: cover property (byte_done && state == ST_WDATA && wp_lat);
  c_poll: cover property (byte_done && state == ST_DEVADDR && busy);
endmodule
